// file: core/pwm_pkg.sv
// Constants shared by the LED PWM intensity block and its time base
package pwm_pkg;
  // Register map (byte address codes)
  localparam logic [7:0] ADDR_MASTER = 8'h0E;
  localparam logic [7:0] ADDR_INDIV_FIRST = 8'h10;
  localparam logic [7:0] ADDR_INDIV_LAST = 8'h17;
  localparam int NUM_INDIV_REGS = 8;
  localparam int NUM_PORTS = 16;

  // Field positions of the master register
  localparam int MASTER_HI = 7;
  localparam int MASTER_LO = 4;
  localparam int GLOBAL_HI = 3;
  localparam int GLOBAL_LO = 0;

  // Values after reset
  localparam logic [7:0] MASTER_RESET = 8'h00;
  localparam logic [7:0] INDIV_RESET = 8'hFF;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Setting encodings
  localparam logic [3:0] SETTING_STATIC = 4'hF;
  localparam logic [3:0] MASTER_OFF = 4'h0;

  // Time base: 15 timeslots of 16 cycles, indices start at zero
  localparam logic [3:0] SLOT_LAST = 4'hE;
  localparam logic [3:0] CYCLE_LAST = 4'hF;
  localparam logic [3:0] TB_RESET = 4'h0;

  // Oscillator emulation from the core clock
  localparam int CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 32_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_RESET = 11'h000;
endpackage

// file: core/timebase_if.sv
// Time base signals between the intensity logic and the oscillator counter
interface timebase_if;
  logic run;
  logic tick;
  logic [3:0] slot;
  logic [3:0] cycle;
  modport src (input run, output tick, output slot, output cycle);
  modport snk (output run, input tick, input slot, input cycle);
endinterface

// file: core/pwm_timebase.sv
// Oscillator divider and timeslot/cycle counter for the PWM period
module pwm_timebase (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Time base
  timebase_if.src tb
);
  import pwm_pkg::*;

  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic [3:0] slot_q;
  logic [3:0] cycle_q;

  // Held at zero while stopped, so a restart begins a fresh period
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= DIV_RESET;
      tick_q <= 1'b0;
    end else if (!tb.run) begin
      div_q <= DIV_RESET;
      tick_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q <= DIV_RESET;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 11'h001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slot_q <= TB_RESET;
      cycle_q <= TB_RESET;
    end else if (!tb.run) begin
      slot_q <= TB_RESET;
      cycle_q <= TB_RESET;
    end else if (tick_q) begin
      cycle_q <= cycle_q + 4'h1;
      if (cycle_q == CYCLE_LAST) begin
        slot_q <= (slot_q == SLOT_LAST) ? TB_RESET : slot_q + 4'h1;
      end
    end
  end

  assign tb.tick = tick_q;
  assign tb.slot = slot_q;
  assign tb.cycle = cycle_q;
endmodule

// file: core/led_pwm_intensity_control.sv
// LED PWM intensity control for 16 open-drain ports and the auxiliary output
// Summary of operation
// - Master value 0x00 to 0x0F makes every output static; other intensity settings ignored.
// - Master 0x10-0xFF with global select clear: each output uses its own nibble.
// - Individual 0xF is static following phase bit; 0x0 to 0xE give PWM.
// - Global select set: only the master register supplies intensity.
// - Setting n: low (n+1)/16 of active time with phase 0, swapped with 1.
// - Setting 0xF: static low for phase bit 0, static high impedance for 1.
// - Blink enabled: phase selects which phase register bit drives each output.
// - Master low nibble is the auxiliary output setting and the global setting.
// - Global setting replaces all 17 individual settings together, never a subset.
// - Global mode: on for master gate times (global nibble + 1) of the 240 cycles, as in individual mode.
// - Period is 15 timeslots of 16 cycles; master gates 1 to 15 timeslots.
// - Time base runs from an internal 32kHz tick, stopped when PWM is off.
// - Master upper nibble zero means 0/15 duty: oscillator off, outputs static.
// - Phase bit 1 leaves a static port high impedance; 0 drives it low.
module led_pwm_intensity_control (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Register access
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Configuration flags
  input wire logic global_sel_in,
  input wire logic blink_enable_in,
  input wire logic blink_flip_in,
  // Phase register bits, bit 16 is the auxiliary output
  input wire logic [16:0] phase0_bits_in,
  input wire logic [16:0] phase1_bits_in,
  // Open-drain ports
  output logic [15:0] port_out,
  output logic [15:0] port_oe_out,
  // Auxiliary seventeenth output
  output logic auxiliary_seventeenth_output_out,
  output logic auxiliary_seventeenth_output_oe_out,
  // Status
  output logic osc_running_out
);
  import pwm_pkg::*;

  logic [7:0] master_and_aux_intensity_q;
  logic [7:0] output_intensity_q [NUM_INDIV_REGS];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [16:0] oe_q;
  logic [16:0] pin_low_q;
  logic run_q;
  logic [3:0] master_gate;
  logic [3:0] global_setting;
  logic [16:0] phase_bit;
  logic [16:0] level;
  logic master_wr;
  logic [NUM_INDIV_REGS-1:0] indiv_wr;
  logic [7:0] rdata_d;
  logic run_d;

  timebase_if tb_bus ();

  function automatic logic is_indiv_addr(input logic [7:0] addr);
    is_indiv_addr = (addr >= ADDR_INDIV_FIRST) && (addr <= ADDR_INDIV_LAST);
  endfunction

  function automatic logic [2:0] indiv_index(input logic [7:0] addr);
    indiv_index = 3'(addr - ADDR_INDIV_FIRST);
  endfunction

  // Open-drain level of one output: 0 pulls the pin low, 1 releases it
  function automatic logic pwm_level(input logic is_static, input logic phase, input logic on);
    logic lvl;
    lvl = phase;
    if (!is_static) begin
      if (phase) begin
        lvl = on;
      end else begin
        lvl = !on;
      end
    end
    pwm_level = lvl;
  endfunction

  pwm_timebase u_timebase (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .tb(tb_bus.src)
  );

  assign master_gate = master_and_aux_intensity_q[MASTER_HI:MASTER_LO];
  assign global_setting = master_and_aux_intensity_q[GLOBAL_HI:GLOBAL_LO];

  // Write decode; writes to unmapped addresses raise no strobe
  always_comb begin
    master_wr = 1'b0;
    indiv_wr = 8'h00;
    if (reg_wr_en_in) begin
      if (reg_addr_in == ADDR_MASTER) begin
        master_wr = 1'b1;
      end else if (is_indiv_addr(reg_addr_in)) begin
        indiv_wr[indiv_index(reg_addr_in)] = 1'b1;
      end
    end
  end

  // Register writes
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      master_and_aux_intensity_q <= MASTER_RESET;
    end else if (master_wr) begin
      master_and_aux_intensity_q <= reg_wdata_in;
    end
  end

  genvar r;
  generate
    for (r = 0; r < NUM_INDIV_REGS; r++) begin : g_indiv
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          output_intensity_q[r] <= INDIV_RESET;
        end else if (indiv_wr[r]) begin
          output_intensity_q[r] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  // Read data mux; unmapped addresses answer zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_en_in) begin
      if (reg_addr_in == ADDR_MASTER) begin
        rdata_d = master_and_aux_intensity_q;
      end else if (is_indiv_addr(reg_addr_in)) begin
        rdata_d = output_intensity_q[indiv_index(reg_addr_in)];
      end else begin
        rdata_d = RDATA_RESET;
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Valid is a one-cycle pulse after each read strobe
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_en_in;
    end
  end

  // Oscillator runs only while the master gate is nonzero; stopping it saves power
  always_comb begin
    run_d = 1'b0;
    if (master_gate != MASTER_OFF) begin
      run_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  assign tb_bus.run = run_q;

  // Per-output waveform; bit 16 is the auxiliary output
  genvar i;
  generate
    for (i = 0; i < 17; i++) begin : g_out
      logic [3:0] own_setting;
      logic [3:0] setting;
      logic is_static;
      logic slot_on;
      logic cycle_on;
      logic pwm_on;
      if (i == NUM_PORTS) begin : g_aux
        // The auxiliary output has no register of its own
        assign own_setting = global_setting;
      end else begin : g_port
        assign own_setting = output_intensity_q[i/2][(i%2)*4 +: 4];
      end
      // Global mode overrides every output at once, never a subset
      always_comb begin
        setting = own_setting;
        if (global_sel_in) begin
          setting = global_setting;
        end
      end
      assign phase_bit[i] = (blink_enable_in && blink_flip_in) ? phase1_bits_in[i] : phase0_bits_in[i];
      always_comb begin
        is_static = 1'b0;
        if (master_gate == MASTER_OFF) begin
          is_static = 1'b1;
        end else if (setting == SETTING_STATIC) begin
          is_static = 1'b1;
        end
      end
      assign slot_on = (tb_bus.slot < master_gate);
      assign cycle_on = (tb_bus.cycle <= setting);
      assign pwm_on = slot_on && cycle_on;
      // Level 0 means pin pulled low; phase bit 1 inverts the waveform
      assign level[i] = pwm_level(is_static, phase_bit[i], pwm_on);
    end
  endgenerate

  // Open drain: enable only while pulling low
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oe_q <= 17'h00000;
    end else begin
      oe_q <= ~level;
    end
  end

  // Driven value is always low; held in a flop so every output is registered
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_low_q <= 17'h00000;
    end else begin
      pin_low_q <= 17'h00000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign port_out = pin_low_q[15:0];
  assign port_oe_out = oe_q[15:0];
  assign auxiliary_seventeenth_output_out = pin_low_q[16];
  assign auxiliary_seventeenth_output_oe_out = oe_q[16];
  assign osc_running_out = run_q;
endmodule

// file: testbench/pwm_properties.sv
// Port checker for the LED PWM intensity block
module pwm_checker (
  // Clock, reset, registers
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  // Phase select and pins
  input wire logic blink_enable_in,
  input wire logic blink_flip_in,
  input wire logic [16:0] phase0_bits_in,
  input wire logic [16:0] phase1_bits_in,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe_out,
  input wire logic auxiliary_seventeenth_output_out,
  input wire logic auxiliary_seventeenth_output_oe_out,
  input wire logic osc_running_out
);
  import pwm_pkg::*;
  logic [7:0] mst_q;
  logic [16:0] ph;
  // Master register rebuilt from port writes, since its body is hidden
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) mst_q <= MASTER_RESET;
    else if (reg_wr_en_in && reg_addr_in == ADDR_MASTER) mst_q <= reg_wdata_in;
  end
  assign ph = (blink_enable_in && blink_flip_in) ? phase1_bits_in : phase0_bits_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_rv; reg_rd_en_in |=> reg_rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rv1; !reg_rd_en_in |=> !reg_rvalid_out; endproperty
  a_rv1: assert property (p_rv1) else $error("extra rvalid");
  property p_rd; reg_rd_en_in && reg_addr_in == ADDR_MASTER |=> reg_rdata_out == $past(mst_q); endproperty
  a_rd: assert property (p_rd) else $error("master readback");
  property p_st; mst_q[7:4] == MASTER_OFF |=> port_oe_out == ~$past(ph[15:0]); endproperty
  a_st: assert property (p_st) else $error("static level");
  property p_ax; mst_q[3:0] == SETTING_STATIC |=> auxiliary_seventeenth_output_oe_out == !$past(ph[16]); endproperty
  a_ax: assert property (p_ax) else $error("aux static");
  property p_on; mst_q[7:4] != MASTER_OFF |=> osc_running_out; endproperty
  a_on: assert property (p_on) else $error("osc stopped");
  property p_off; mst_q[7:4] == MASTER_OFF |=> !osc_running_out; endproperty
  a_off: assert property (p_off) else $error("osc running");
  property p_lo; port_out == 16'h0000; endproperty
  a_lo: assert property (p_lo) else $error("drive not low");
  property p_axlo; auxiliary_seventeenth_output_out == 1'b0; endproperty
  a_axlo: assert property (p_axlo) else $error("aux drive not low");
endmodule

// file: testbench/testbench.sv
// Bench for the LED PWM intensity block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_pkg::*;
  logic core_clk_in = 1'b0, arst_n_in = 1'b0, reg_wr_en_in = 1'b0, reg_rd_en_in = 1'b0;
  logic global_sel_in = 1'b0, blink_enable_in = 1'b0, blink_flip_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic [16:0] phase0_bits_in = 17'h00000, phase1_bits_in = 17'h00000;
  logic [15:0] port_out, port_oe_out;
  logic reg_rvalid_out, auxiliary_seventeenth_output_out, auxiliary_seventeenth_output_oe_out, osc_running_out;
  wire [3:0] oe4 = {auxiliary_seventeenth_output_oe_out, port_oe_out[2:0]};
  int num_errors = 0;
  int check_count = 0;
  led_pwm_intensity_control u_led_pwm_intensity_control (.*);
  always #10 core_clk_in = ~core_clk_in;
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_wr_en_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    step(1);
    reg_wr_en_in = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    step(1);
    reg_rd_en_in = 1'b1;
    reg_addr_in = a;
    step(1);
    reg_rd_en_in = 1'b0;
    check("rvalid", {7'h00, reg_rvalid_out}, 8'h01);
    check("rdata", reg_rdata_out, exp);
  endtask
  task automatic test_regs();
    phase0_bits_in = 17'h1A5A5;
    rd_reg(ADDR_MASTER, MASTER_RESET);
    rd_reg(ADDR_INDIV_FIRST, INDIV_RESET);
    wr_reg(8'h0F, 8'h5A);
    rd_reg(8'h0F, RDATA_RESET);
    wr_reg(ADDR_INDIV_LAST, 8'hA5);
    rd_reg(ADDR_INDIV_LAST, 8'hA5);
    check("static", {4'h0, oe4}, 8'h02);
    check("osc", {7'h00, osc_running_out}, 8'h00);
    $display("test_regs done");
  endtask
  task automatic test_pwm();
    logic on3, on5;
    logic [3:0] exp;
    phase0_bits_in = 17'h00004;
    phase1_bits_in = 17'h00005;
    wr_reg(ADDR_INDIV_FIRST, 8'hF5);
    wr_reg(8'h11, 8'h05);
    wr_reg(ADDR_MASTER, 8'h23);
    repeat (8) if (osc_running_out !== 1'b1) step(1);
    // Sample mid-cycle so the output lag of a clock or two never matters
    step(781);
    for (int k = 0; k < 32; k++) begin
      on3 = k[3:0] <= 4'h3;
      on5 = k[3:0] <= 4'h5;
      exp = (k < 16) ? {on3, !on5, 1'b1, on5} : {on3, !on3, on3, !on3};
      check("pwm", {4'h0, oe4}, {4'h0, exp});
      if (k == 15) begin
        global_sel_in = 1'b1;
        blink_enable_in = 1'b1;
        blink_flip_in = 1'b1;
      end
      step(1562);
    end
    wr_reg(ADDR_MASTER, 8'h0F);
    step(2);
    check("stop", {3'h0, osc_running_out, oe4}, 8'h0A);
    $display("test_pwm done");
  endtask
  initial begin
    step(8);
    arst_n_in = 1'b1;
    test_regs();
    test_pwm();
    give_verdict();
  end
  initial begin
    step(70000);
    num_errors++;
    give_verdict();
  end
endmodule
bind led_pwm_intensity_control pwm_checker u_pwm_checker (.*);
